// ==== bztg_buzzer.v ====
// bztg_buzzer.v: buzzer tone generator top, avalon-mm register slave.
// assumes the doubled slow clock arrives as a level synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "bztg_defines.vh"

module bztg_buzzer #(
    parameter GATE_W = 10
) (
    // clock and reset
    input wire clk_i,
    input wire reset_n_i,
    // avalon-mm slave
    input wire [`BZTG_ADDR_W-1:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output reg [31:0] avs_readdata_o,
    output reg avs_waitrequest_o,
    output reg avs_response_o,
    // doubled slow clock as a level
    input wire slow_clock_x2_i,
    // tone pin
    output reg tone_out_pin_o,
    output reg tone_active_o
);
    reg [7:0] buzzer_control;
    reg [7:0] buzzer_pattern_select;
    reg [7:0] buzzer_pitch_select;
    reg [7:0] buzzer_duty_select;
    reg slow_q;
    reg ack;
    reg [31:0] next_rdata;
    reg next_resp;
    wire req;
    wire [1:0] word;
    wire mapped;
    wire slow_tick;
    wire tone;
    wire single_done;
    wire run;

    // word addressed: avs address bits 1:0 pick register, upper must be 0
    assign word = avs_address_i[1:0];
    assign mapped = (avs_address_i[`BZTG_ADDR_W-1:2] == 2'h0);
    assign req = (avs_read_i || avs_write_i) && !ack;
    assign run = buzzer_control[`BZTG_RUN_BIT];

    // rising edge of the doubled slow clock, input taken as synchronous
    assign slow_tick = slow_clock_x2_i && !slow_q;

    // one wait cycle then acknowledge, keeps the read data registered
    always @* begin
        next_rdata = 32'h0000_0000;
        next_resp = 1'b0;
        case (word)
            `BZTG_WORD_CONTROL: next_rdata[7:0] = buzzer_control;
            `BZTG_WORD_PATTERN: next_rdata[7:0] = buzzer_pattern_select;
            `BZTG_WORD_PITCH: next_rdata[7:0] = buzzer_pitch_select;
            default: next_rdata[7:0] = buzzer_duty_select;
        endcase
        if (!mapped) begin
            next_rdata = 32'h0000_0000;
            next_resp = 1'b1;
        end
    end

    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            buzzer_control <= `BZTG_RESET_BYTE;
            buzzer_pattern_select <= `BZTG_RESET_BYTE;
            buzzer_pitch_select <= `BZTG_RESET_BYTE;
            buzzer_duty_select <= `BZTG_RESET_BYTE;
            avs_readdata_o <= 32'h0000_0000;
            avs_waitrequest_o <= 1'b1;
            avs_response_o <= 1'b0;
            ack <= 1'b0;
            slow_q <= 1'b0;
            tone_out_pin_o <= 1'b0;
            tone_active_o <= 1'b0;
        end else begin
            slow_q <= slow_clock_x2_i;
            tone_out_pin_o <= tone;
            tone_active_o <= run && !single_done;
            ack <= req;
            avs_waitrequest_o <= !req;
            if (req) begin
                avs_readdata_o <= avs_read_i ? next_rdata : 32'h0000_0000;
                avs_response_o <= next_resp;
            end
            // only low byte lane holds register bits; upper bits kept
            if (req && avs_write_i && mapped && avs_byteenable_i[0]) begin
                case (word)
                    `BZTG_WORD_CONTROL:
                        buzzer_control <= avs_writedata_i[7:0];
                    `BZTG_WORD_PATTERN:
                        buzzer_pattern_select <= avs_writedata_i[7:0];
                    `BZTG_WORD_PITCH:
                        buzzer_pitch_select <= avs_writedata_i[7:0];
                    default:
                        buzzer_duty_select <= avs_writedata_i[7:0];
                endcase
            end
        end
    end

    // pitch codes give 8192/(pitch+1) Hz per 131 kHz doubled clock
    bztg_tone_core #(
        .GATE_W(GATE_W)
    ) u_core (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .run_i(run),
        .slow_tick_i(slow_tick),
        .pattern_i(buzzer_pattern_select[`BZTG_PAT_MSB:0]),
        .pitch_i(buzzer_pitch_select[`BZTG_PITCH_MSB:0]),
        .duty_i(buzzer_duty_select[`BZTG_DUTY_MSB:0]),
        .tone_o(tone),
        .single_done_o(single_done)
    );
endmodule // bztg_buzzer
`default_nettype wire

// ==== bztg_defines.vh ====
// bztg_defines.vh: register map, field positions and reset values of the
// buzzer tone generator.
// assumes inclusion by bare name from the design files of this folder.
`ifndef BZTG_DEFINES_VH
`define BZTG_DEFINES_VH

// register indices (printed offsets are not multiples of four)
`define BZTG_IDX_CONTROL 16'hF2C0
`define BZTG_IDX_PATTERN 16'hF2C1
`define BZTG_IDX_PITCH 16'hF2C2
`define BZTG_IDX_DUTY 16'hF2C3
`define BZTG_IDX_BASE 16'hF2C0
`define BZTG_ADDR_W 4
// word index within the block window, address = index
`define BZTG_WORD_CONTROL 2'h0
`define BZTG_WORD_PATTERN 2'h1
`define BZTG_WORD_PITCH 2'h2
`define BZTG_WORD_DUTY 2'h3

// fields
`define BZTG_RUN_BIT 0
`define BZTG_PAT_MSB 1
`define BZTG_PITCH_MSB 2
`define BZTG_DUTY_MSB 3
`define BZTG_RESET_BYTE 8'h00

// pattern codes
`define BZTG_PAT_INTER1 2'h0
`define BZTG_PAT_INTER2 2'h1
`define BZTG_PAT_SINGLE 2'h2
`define BZTG_PAT_CONT 2'h3

// tone period is 16 slots of pitch + 1 ticks each
`define BZTG_SLOT_MAX 4'hF
`define BZTG_DUTY_MIN 4'h1

`endif

// ==== bztg_tone_core.v ====
// bztg_tone_core.v: tone waveform engine running on enables from the
// doubled slow clock.
// assumes slow_tick_i is a one-cycle pulse per doubled slow clock edge.
`timescale 1ns/1ps
`default_nettype none
`include "bztg_defines.vh"

module bztg_tone_core #(
    parameter GATE_W = 10,
    parameter [9:0] INTER1_ON = 10'h0FF,
    parameter [9:0] INTER1_LEN = 10'h1FF,
    parameter [9:0] INTER2_ON = 10'h07F,
    parameter [9:0] INTER2_LEN = 10'h0FF,
    parameter [9:0] SINGLE_LEN = 10'h3FF
) (
    // clock and reset
    input wire clk_i,
    input wire reset_n_i,
    // settings
    input wire run_i,
    input wire slow_tick_i,
    input wire [1:0] pattern_i,
    input wire [2:0] pitch_i,
    input wire [3:0] duty_i,
    // tone
    output reg tone_o,
    output reg single_done_o
);
    reg [2:0] step;
    reg [3:0] slot;
    reg [GATE_W-1:0] gate_cnt;
    wire [3:0] duty_eff;
    wire period_end;
    reg gate_on;

    // code 0 behaves as code 1
    assign duty_eff = (duty_i == 4'h0) ? `BZTG_DUTY_MIN : duty_i;
    assign period_end = (step == pitch_i) && (slot == `BZTG_SLOT_MAX);

    // gating per pattern; counted in tone periods
    always @* begin
        case (pattern_i)
            `BZTG_PAT_INTER1: gate_on = (gate_cnt <= INTER1_ON);
            `BZTG_PAT_INTER2: gate_on = (gate_cnt <= INTER2_ON);
            `BZTG_PAT_SINGLE: gate_on = !single_done_o;
            default: gate_on = 1'b1;
        endcase
    end

    always @(posedge clk_i) begin
        if (!reset_n_i || !run_i) begin
            step <= 3'h0;
            slot <= 4'h0;
            gate_cnt <= {GATE_W{1'b0}};
            tone_o <= 1'b0;
            single_done_o <= 1'b0;
        end else if (slow_tick_i) begin
            // period = 16 * (pitch + 1) ticks, high for duty slots
            if (step == pitch_i) begin
                step <= 3'h0;
                slot <= slot + 4'h1;
            end else begin
                step <= step + 3'h1;
            end
            tone_o <= gate_on && (slot < duty_eff);
            if (period_end) begin
                case (pattern_i)
                    `BZTG_PAT_INTER1:
                        gate_cnt <= (gate_cnt >= INTER1_LEN) ?
                            {GATE_W{1'b0}} : gate_cnt + 1'b1;
                    `BZTG_PAT_INTER2:
                        gate_cnt <= (gate_cnt >= INTER2_LEN) ?
                            {GATE_W{1'b0}} : gate_cnt + 1'b1;
                    `BZTG_PAT_SINGLE: begin
                        if (gate_cnt >= SINGLE_LEN)
                            single_done_o <= 1'b1;
                        else
                            gate_cnt <= gate_cnt + 1'b1;
                    end
                    default: gate_cnt <= {GATE_W{1'b0}};
                endcase
            end
        end
    end
endmodule // bztg_tone_core
`default_nettype wire

// ==== bztg_properties.sv ====
// checker: bus answer and tone timing at the buzzer top ports
// assumes a slow clock far slower than clk_i
`timescale 1ns/1ps
`default_nettype none
module bztg_properties (
    // clock, reset, bus
    input wire logic clk_i, reset_n_i, avs_read_i, avs_write_i,
    input wire logic [3:0] avs_address_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic avs_waitrequest_o,
    // tone
    input wire logic slow_clock_x2_i, tone_out_pin_o, tone_active_o
);
    logic [2:0] p;
    logic [3:0] d;
    logic [1:0] m;
    logic sr, tp, ok;
    logic [15:0] hi, per;
    wire tk = slow_clock_x2_i & ~sr;
    wire up = tone_out_pin_o & ~tp;
    wire [15:0] pl = {p, 4'h0} + 16'h10;
    wire wr = avs_write_i & ~avs_waitrequest_o;
    always @(posedge clk_i) begin
        sr <= slow_clock_x2_i;
        tp <= tone_out_pin_o;
        hi <= up ? 16'h0 : hi + (tk & tone_out_pin_o);
        per <= up ? 16'h0 : per + tk;
        // first period after a start is partial, so it is not judged
        ok <= tone_active_o & (ok | up);
        if (!reset_n_i)
            {m, p, d} <= 9'h0;
        else if (wr && avs_address_i == 4'h1)
            m <= avs_writedata_i[1:0];
        else if (wr && avs_address_i == 4'h2)
            p <= avs_writedata_i[2:0];
        else if (wr && avs_address_i == 4'h3)
            d <= avs_writedata_i[3:0];
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    stop_low_a: assert property (
        !tone_active_o [*3] |-> !tone_out_pin_o) else $error("stop");
    run_start_a: assert property (
        $rose(tone_active_o) |-> ##[0:80] tone_out_pin_o) else $error("go");
    tick_paced_a: assert property (
        up |-> $past(tk) || $past(tk, 2) || $past(tk, 3)) else $error("tk");
    high_len_a: assert property (
        $fell(tone_out_pin_o) && tone_active_o
        |-> hi == (d ? d : 4'h1) * (p + 16'h1)) else $error("duty");
    period_len_a: assert property (
        up && ok && m == 2'h3 |-> per == pl) else $error("period");
    inter_one_a: assert property (
        up && ok && m == 2'h0 |-> per == pl || per == pl * 16'd257)
        else $error("gate1");
    inter_two_a: assert property (
        up && ok && m == 2'h1 |-> per == pl || per == pl * 16'd129)
        else $error("gate2");
    bus_answer_a: assert property (
        (avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o ##1 avs_waitrequest_o) else $error("bus");
    cover property (up && ok && m == 2'h3);
    cover property (up && ok && per > pl);
    cover property (wr && avs_address_i == 4'h0);
    cover property (up && ok && m == 2'h2);
endmodule // bztg_properties
bind bztg_buzzer bztg_properties u_bztg_properties (.clk_i, .reset_n_i,
    .avs_read_i, .avs_write_i, .avs_address_i, .avs_writedata_i,
    .avs_waitrequest_o, .slow_clock_x2_i, .tone_out_pin_o, .tone_active_o);
`default_nettype wire

// ==== bztg_piezo.sv ====
// piezo model: times tone pin pulses in clk cycles
// assumes a push-pull pin level sampled on clk_i
`timescale 1ns/1ps
`default_nettype none
module bztg_piezo (
    input wire logic clk_i, tone_i,
    output int rises, hi_len, per_len
);
    int t, tr;
    logic q = 1'b0;
    always @(posedge clk_i) begin
        t <= t + 1;
        q <= tone_i; // push-pull pin level
        if (tone_i & ~q) begin
            rises <= rises + 1;
            per_len <= t - tr;
            tr <= t;
        end
        if (~tone_i & q)
            hi_len <= t - tr;
    end
endmodule // bztg_piezo
`default_nettype wire

// ==== test_bztg_buzzer.sv ====
// bench of the buzzer top: registers, pitches, duties, patterns
// assumes the doubled slow clock made here, 4 clk per cycle
`timescale 1ns/1ps
`default_nettype none
module test_bztg_buzzer;
    logic clk_i = 0, reset_n_i = 0, avs_read_i = 0, avs_write_i = 0;
    logic [3:0] avs_address_i = 4'h0;
    logic [31:0] avs_writedata_i = 32'h0, q;
    logic [1:0] sk = 2'h0;
    logic en = 0, rs;
    wire [31:0] avs_readdata_o;
    wire avs_waitrequest_o, avs_response_o, tone_out_pin_o, tone_active_o;
    int fails = 0, num_checks = 0, rises, hi_len, per_len, mdl[4], r0, d;
    bztg_buzzer u_bztg_buzzer (.clk_i, .reset_n_i, .avs_address_i,
        .avs_read_i, .avs_write_i, .avs_writedata_i,
        .avs_byteenable_i(4'hF), .avs_readdata_o, .avs_waitrequest_o,
        .avs_response_o, .slow_clock_x2_i(sk[1]), .tone_out_pin_o,
        .tone_active_o);
    bztg_piezo u_bztg_piezo (.clk_i, .tone_i(tone_out_pin_o), .rises,
        .hi_len, .per_len);
    initial forever #25 clk_i = ~clk_i;
    // slow clock stands until enabled
    always @(posedge clk_i) if (en) sk <= sk + 2'h1;
    task chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("Error at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task bus(input logic w, input logic [3:0] a, input logic [7:0] v);
        avs_address_i <= a;
        avs_write_i <= w;
        avs_read_i <= !w;
        avs_writedata_i <= {24'h0, v};
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        rs = avs_response_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task close_out;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        #(80000 * 50);
        fails++;
        close_out;
    end
    initial begin
        d = $urandom(68);
        repeat (4) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(posedge clk_i);
        for (int a = 0; a < 5; a++) begin
            bus(0, a, 0);
            chk(q, 0);
            chk(rs, a == 4);
        end
        bus(1, 4'h9, 8'hFF);
        chk(rs, 1);
        bus(0, 4'h1, 0);
        chk(q, 0);
        for (int a = 0; a < 4; a++) begin
            mdl[a] = $urandom % 256 & (a ? 255 : 254);
            bus(1, a, mdl[a]);
            bus(0, a, 0);
            chk(q, mdl[a]);
        end
        $display("test registers done");
        en <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            d = i == 0 ? 0 : i == 7 ? 15 : $urandom % 16;
            bus(1, 1, 3);
            bus(1, 3, d);
            bus(1, 2, i);
            bus(1, 0, 1);
            repeat (200 * (i + 1)) @(posedge clk_i);
            chk(per_len, 64 * (i + 1));
            chk(hi_len, (d ? d : 1) * 4 * (i + 1));
            bus(1, 0, 0);
            repeat (4) @(posedge clk_i);
            chk(tone_out_pin_o, 0);
            chk(tone_active_o, 0);
        end
        $display("test pitch and duty done");
        for (int m = 0; m < 2; m++) begin
            bus(1, 1, m);
            bus(1, 2, 0);
            bus(1, 3, 8);
            r0 = rises;
            bus(1, 0, 1);
            // slack below one 64-clk period, first rise of the next burst counts, later ones must not
            repeat (16384 * (2 - m) + 40) @(posedge clk_i);
            chk(rises - r0, 128 * (2 - m) + 1);
            bus(1, 0, 0);
        end
        $display("test patterns done");
        bus(1, 1, 2);
        r0 = rises;
        bus(1, 0, 1);
        repeat (1000) @(posedge clk_i);
        chk(tone_active_o, 1);
        chk(rises - r0, 16);
        chk(per_len, 64);
        bus(1, 0, 0);
        $display("test single sound done");
        close_out;
    end
endmodule // test_bztg_buzzer
`default_nettype wire
